// ### hw/pic_pkg.sv
// Constants shared by the parallel I/O controller: register map, reset values, field layout.
// Assumes a 32-bit Avalon-MM slave port with byte addresses and a single system clock.
//
// Summary of operation
// - Registers are 32 bits, bit n is line n.
// - Writes to unimplemented line bits change nothing.
// - Unimplemented line bits always read zero.
// - Lines without peripheral always owned, status one.
// - Output value writable only where direct-write enabled.
// - Pin sample tracks pins while clock runs.
// - Pending resets zero, records changes after reset.
// - Unmapped offsets ignore writes, read zero.
// - Enable/disable writes of one set/clear status.
// - Events set pending; irq ORs masked pending bits.
// - Reading pending clears; levels keep re-asserting.
// - Write lock blocks writes to 16 config offsets, flags violation, source.
package pic_pkg;

	localparam int unsigned NUM_LINES = 32;
	localparam int unsigned ADDR_W    = 9;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [8:0] OFS_OWN_EN   = 9'h000;
	localparam logic [8:0] OFS_OWN_DIS  = 9'h004;
	localparam logic [8:0] OFS_OWN_ST   = 9'h008;
	localparam logic [8:0] OFS_OE_EN    = 9'h010;
	localparam logic [8:0] OFS_OE_DIS   = 9'h014;
	localparam logic [8:0] OFS_OE_ST    = 9'h018;
	localparam logic [8:0] OFS_GF_EN    = 9'h020;
	localparam logic [8:0] OFS_GF_DIS   = 9'h024;
	localparam logic [8:0] OFS_GF_ST    = 9'h028;
	localparam logic [8:0] OFS_OUT_SET  = 9'h030;
	localparam logic [8:0] OFS_OUT_CLR  = 9'h034;
	localparam logic [8:0] OFS_OUT_VAL  = 9'h038;
	localparam logic [8:0] OFS_PIN_SMP  = 9'h03C;
	localparam logic [8:0] OFS_IRQ_EN   = 9'h040;
	localparam logic [8:0] OFS_IRQ_DIS  = 9'h044;
	localparam logic [8:0] OFS_IRQ_MASK = 9'h048;
	localparam logic [8:0] OFS_IRQ_PEND = 9'h04C;
	localparam logic [8:0] OFS_OD_EN    = 9'h050;
	localparam logic [8:0] OFS_OD_DIS   = 9'h054;
	localparam logic [8:0] OFS_OD_ST    = 9'h058;
	localparam logic [8:0] OFS_PU_DIS   = 9'h060;
	localparam logic [8:0] OFS_PU_EN    = 9'h064;
	localparam logic [8:0] OFS_PU_ST    = 9'h068;
	localparam logic [8:0] OFS_PSEL_LO  = 9'h070;
	localparam logic [8:0] OFS_PSEL_HI  = 9'h074;
	localparam logic [8:0] OFS_DB_DIS   = 9'h080;
	localparam logic [8:0] OFS_DB_EN    = 9'h084;
	localparam logic [8:0] OFS_DB_ST    = 9'h088;
	localparam logic [8:0] OFS_DB_DIV   = 9'h08C;
	localparam logic [8:0] OFS_PD_DIS   = 9'h090;
	localparam logic [8:0] OFS_PD_EN    = 9'h094;
	localparam logic [8:0] OFS_PD_ST    = 9'h098;
	localparam logic [8:0] OFS_DW_EN    = 9'h0A0;
	localparam logic [8:0] OFS_DW_DIS   = 9'h0A4;
	localparam logic [8:0] OFS_DW_ST    = 9'h0A8;
	localparam logic [8:0] OFS_AIM_EN   = 9'h0B0;
	localparam logic [8:0] OFS_AIM_DIS  = 9'h0B4;
	localparam logic [8:0] OFS_AIM_MASK = 9'h0B8;
	localparam logic [8:0] OFS_EDGE_SEL = 9'h0C0;
	localparam logic [8:0] OFS_LVL_SEL  = 9'h0C4;
	localparam logic [8:0] OFS_EL_ST    = 9'h0C8;
	localparam logic [8:0] OFS_FALL_SEL = 9'h0D0;
	localparam logic [8:0] OFS_RISE_SEL = 9'h0D4;
	localparam logic [8:0] OFS_POL_ST   = 9'h0D8;
	localparam logic [8:0] OFS_WL_MODE  = 9'h0E4;
	localparam logic [8:0] OFS_WL_ST    = 9'h0E8;
	localparam logic [8:0] OFS_SCHMITT  = 9'h100;
	localparam logic [8:0] OFS_DRIVE    = 9'h110;

	// ---------------------------------------------------------------
	// Reset values and fields
	// ---------------------------------------------------------------
	localparam logic [31:0] RST_ZERO     = 32'h0000_0000;
	localparam logic [31:0] RST_ALL_ONES = 32'hFFFF_FFFF;
	localparam int unsigned WL_ENABLE_BIT  = 0;
	localparam int unsigned WL_VIOL_BIT    = 0;
	localparam int unsigned WL_SRC_LSB     = 8;
	localparam int unsigned WL_SRC_W       = 16;

	typedef enum logic {BS_IDLE, BS_DONE} pic_bus_state_t;

endpackage

// ### hw/pic_line_filter.sv
// Per-line glitch / debounce filter for the parallel I/O controller.
// Assumes raw levels already registered in the system clock domain.
`timescale 1ns/1ps
module pic_line_filter
	import pic_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [31:0] raw_i,
	input  wire logic [31:0] filt_en_i,
	input  wire logic [31:0] slow_en_i,
	input  wire logic [31:0] div_i,
	output logic      [31:0] level_o
);
	logic [31:0] cnt_r;
	logic        tick;
	logic [31:0] smp_r;
	logic [31:0] filt_r;
	logic [31:0] step;

	// Debounce tick: one pulse every div_i+1 clocks
	assign tick = (cnt_r >= div_i);
	// Only lines in slow mode wait for the tick; the rest step every clock
	assign step = ({NUM_LINES{tick}} & slow_en_i) | ~slow_en_i;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r <= RST_ZERO;
		end else if (tick) begin
			cnt_r <= RST_ZERO;
		end else begin
			cnt_r <= cnt_r + 32'h0000_0001;
		end
	end

	// A level passes only once seen on two consecutive steps
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			smp_r  <= RST_ZERO;
			filt_r <= RST_ZERO;
		end else begin
			smp_r  <= (smp_r & ~step) | (raw_i & step);
			filt_r <= (filt_r & ~(step & ~(raw_i ^ smp_r))) | (raw_i & smp_r & step);
		end
	end

	assign level_o = (filt_r & filt_en_i) | (raw_i & ~filt_en_i);
endmodule

// ### hw/pic_event_detect.sv
// Input change and additional edge/level event detector for all lines.
// Assumes filtered levels in the system clock domain.
`timescale 1ns/1ps
module pic_event_detect
	import pic_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [31:0] level_i,
	input  wire logic [31:0] extra_mode_i,
	input  wire logic [31:0] level_mode_i,
	input  wire logic [31:0] high_rise_i,
	output logic      [31:0] event_o
);
	logic        primed_r;
	logic [31:0] prev_r;
	logic [31:0] chg;
	logic [31:0] edge_ev;
	logic [31:0] lvl_ev;

	// First edge after reset only loads the history, so no false change
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prev_r   <= RST_ZERO;
			primed_r <= 1'b0;
		end else begin
			prev_r   <= level_i;
			primed_r <= 1'b1;
		end
	end

	assign chg     = primed_r ? (level_i ^ prev_r) : RST_ZERO;
	assign edge_ev = chg & ~(level_i ^ high_rise_i);
	assign lvl_ev  = ~(level_i ^ high_rise_i);

	// Level sources fire every cycle while their condition holds
	assign event_o = (chg & ~extra_mode_i)
		| (extra_mode_i & ~level_mode_i & edge_ev)
		| (extra_mode_i & level_mode_i & lvl_ev);
endmodule

// ### hw/pic_parallel_io.sv
// Parallel I/O controller: 32 lines, register file on Avalon-MM, pin mux and interrupt.
// Assumes pad and peripheral signals synchronous to sys_clk_i; one clock domain.
`timescale 1ns/1ps
module pic_parallel_io
	import pic_pkg::*;
#(
	parameter logic [31:0] IMPL_MASK    = 32'hFFFF_FFFF,
	parameter logic [31:0] MUX_MASK     = 32'hFFFF_FFFF,
	parameter logic [31:0] OWN_RST      = 32'hFFFF_FFFF,
	parameter logic [31:0] PULLUP_RST   = 32'h0000_0000,
	parameter logic [31:0] PULLDOWN_RST = 32'h0000_0000
) (
	input  wire logic         sys_clk_i,
	input  wire logic         rst_n_i,
	input  wire logic [8:0]   avs_address_i,
	input  wire logic         avs_read_i,
	input  wire logic         avs_write_i,
	input  wire logic [31:0]  avs_writedata_i,
	input  wire logic [3:0]   avs_byteenable_i,
	output logic      [31:0]  avs_readdata_o,
	output logic              avs_waitrequest_o,
	input  wire logic [31:0]  pad_in_i,
	output logic      [31:0]  pad_out_o,
	output logic      [31:0]  pad_oe_o,
	output logic      [31:0]  pad_pullup_o,
	output logic      [31:0]  pad_pulldown_o,
	output logic      [31:0]  pad_schmitt_off_o,
	output logic      [31:0]  pad_drive_o,
	input  wire logic [127:0] periph_out_i,
	input  wire logic [127:0] periph_oe_i,
	output logic      [31:0]  periph_in_o,
	output logic              irq_o
);
	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] set_clr(input logic [31:0] cur,
		input logic [31:0] set, input logic [31:0] clr);
		set_clr = (cur | set) & ~clr;
	endfunction

	function automatic logic is_locked_ofs(input logic [8:0] a);
		case (a)
			OFS_OWN_EN, OFS_OWN_DIS, OFS_OE_EN, OFS_OE_DIS,
			OFS_GF_EN, OFS_GF_DIS, OFS_OD_EN, OFS_OD_DIS,
			OFS_PU_DIS, OFS_PU_EN, OFS_PSEL_LO, OFS_PSEL_HI,
			OFS_DW_EN, OFS_DW_DIS, OFS_PD_DIS, OFS_PD_EN: is_locked_ofs = 1'b1;
			default: is_locked_ofs = 1'b0;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// Bus slave
	// ---------------------------------------------------------------
	pic_bus_state_t bus_state_r;
	logic [31:0]    readdata_r;
	logic [31:0]    rd_val;
	logic           req;
	logic           acc;
	logic           wr_acc;
	logic           rd_acc;
	logic           lock_en;
	logic           wr_ok;
	logic [31:0]    be_mask;
	logic [31:0]    wd;
	logic [31:0]    wreg;

	assign req               = avs_read_i | avs_write_i;
	assign avs_waitrequest_o = req & (bus_state_r != BS_DONE);
	assign acc               = req & (bus_state_r == BS_DONE);
	assign wr_acc            = acc & avs_write_i;
	assign rd_acc            = acc & avs_read_i;
	assign be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
		{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
	assign wreg    = avs_writedata_i & be_mask;
	assign wd      = wreg & IMPL_MASK;
	assign wr_ok   = wr_acc & ~(lock_en & is_locked_ofs(avs_address_i));

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bus_state_r <= BS_IDLE;
		end else begin
			case (bus_state_r)
				BS_IDLE: begin
					if (req) begin
						bus_state_r <= BS_DONE;
					end
				end
				BS_DONE: bus_state_r <= BS_IDLE;
				default: bus_state_r <= BS_IDLE;
			endcase
		end
	end

	// Read data is caught at the wait cycle and held through the accept edge
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			readdata_r <= RST_ZERO;
		end else if (avs_read_i && bus_state_r == BS_IDLE) begin
			readdata_r <= rd_val;
		end
	end
	assign avs_readdata_o = readdata_r;

	function automatic logic wr_at(input logic [8:0] a);
		wr_at = wr_ok && (avs_address_i == a);
	endfunction

	// ---------------------------------------------------------------
	// Set/clear/status register groups
	// ---------------------------------------------------------------
	logic [31:0] own_r;
	logic [31:0] oe_r;
	logic [31:0] gf_r;
	logic [31:0] out_r;
	logic [31:0] imask_r;
	logic [31:0] od_r;
	logic [31:0] pu_r;
	logic [31:0] pd_r;
	logic [31:0] psel_lo_r;
	logic [31:0] psel_hi_r;
	logic [31:0] db_r;
	logic [31:0] db_div_r;
	logic [31:0] dw_r;
	logic [31:0] aim_r;
	logic [31:0] elvl_r;
	logic [31:0] pol_r;
	logic [31:0] schmitt_r;
	logic [31:0] drive_r;
	logic [31:0] own_view;
	logic [31:0] dw_mask;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			own_r <= OWN_RST;
			oe_r  <= RST_ZERO;
			gf_r  <= RST_ZERO;
			od_r  <= RST_ZERO;
			pu_r  <= PULLUP_RST;
			pd_r  <= PULLDOWN_RST;
			dw_r  <= RST_ZERO;
			db_r  <= RST_ZERO;
		end else begin
			own_r <= set_clr(own_r, wr_at(OFS_OWN_EN) ? wd : RST_ZERO,
				wr_at(OFS_OWN_DIS) ? wd : RST_ZERO);
			oe_r  <= set_clr(oe_r, wr_at(OFS_OE_EN) ? wd : RST_ZERO,
				wr_at(OFS_OE_DIS) ? wd : RST_ZERO);
			gf_r  <= set_clr(gf_r, wr_at(OFS_GF_EN) ? wd : RST_ZERO,
				wr_at(OFS_GF_DIS) ? wd : RST_ZERO);
			od_r  <= set_clr(od_r, wr_at(OFS_OD_EN) ? wd : RST_ZERO,
				wr_at(OFS_OD_DIS) ? wd : RST_ZERO);
			pu_r  <= set_clr(pu_r, wr_at(OFS_PU_EN) ? wd : RST_ZERO,
				wr_at(OFS_PU_DIS) ? wd : RST_ZERO);
			pd_r  <= set_clr(pd_r, wr_at(OFS_PD_EN) ? wd : RST_ZERO,
				wr_at(OFS_PD_DIS) ? wd : RST_ZERO);
			dw_r  <= set_clr(dw_r, wr_at(OFS_DW_EN) ? wd : RST_ZERO,
				wr_at(OFS_DW_DIS) ? wd : RST_ZERO);
			db_r  <= set_clr(db_r, wr_at(OFS_DB_EN) ? wd : RST_ZERO,
				wr_at(OFS_DB_DIS) ? wd : RST_ZERO);
		end
	end

	// Interrupt mode groups
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			imask_r <= RST_ZERO;
			aim_r   <= RST_ZERO;
			elvl_r  <= RST_ZERO;
			pol_r   <= RST_ZERO;
		end else begin
			imask_r <= set_clr(imask_r, wr_at(OFS_IRQ_EN) ? wd : RST_ZERO,
				wr_at(OFS_IRQ_DIS) ? wd : RST_ZERO);
			aim_r   <= set_clr(aim_r, wr_at(OFS_AIM_EN) ? wd : RST_ZERO,
				wr_at(OFS_AIM_DIS) ? wd : RST_ZERO);
			elvl_r  <= set_clr(elvl_r, wr_at(OFS_LVL_SEL) ? wd : RST_ZERO,
				wr_at(OFS_EDGE_SEL) ? wd : RST_ZERO);
			pol_r   <= set_clr(pol_r, wr_at(OFS_RISE_SEL) ? wd : RST_ZERO,
				wr_at(OFS_FALL_SEL) ? wd : RST_ZERO);
		end
	end

	// Plain read/write registers
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			psel_lo_r <= RST_ZERO;
			psel_hi_r <= RST_ZERO;
			db_div_r  <= RST_ZERO;
			schmitt_r <= RST_ZERO;
			drive_r   <= RST_ZERO;
		end else begin
			psel_lo_r <= wr_at(OFS_PSEL_LO) ? ((psel_lo_r & ~be_mask) | wd) : psel_lo_r;
			psel_hi_r <= wr_at(OFS_PSEL_HI) ? ((psel_hi_r & ~be_mask) | wd) : psel_hi_r;
			db_div_r  <= wr_at(OFS_DB_DIV) ? ((db_div_r & ~be_mask) | wreg) : db_div_r;
			schmitt_r <= wr_at(OFS_SCHMITT) ? ((schmitt_r & ~be_mask) | wd) : schmitt_r;
			drive_r   <= wr_at(OFS_DRIVE) ? ((drive_r & ~be_mask) | wd) : drive_r;
		end
	end

	// Output level: set/clear always, direct write only on enabled lines
	assign dw_mask = dw_r & be_mask & IMPL_MASK;
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			out_r <= RST_ZERO;
		end else if (wr_at(OFS_OUT_VAL)) begin
			out_r <= (out_r & ~dw_mask) | (avs_writedata_i & dw_mask);
		end else begin
			out_r <= set_clr(out_r, wr_at(OFS_OUT_SET) ? wd : RST_ZERO,
				wr_at(OFS_OUT_CLR) ? wd : RST_ZERO);
		end
	end

	// Lines with no peripheral stay owned by the controller
	assign own_view = own_r | ~MUX_MASK;

	// ---------------------------------------------------------------
	// Pin sampling, filtering and events
	// ---------------------------------------------------------------
	logic [31:0] pin_smp_r;
	logic [31:0] level;
	logic [31:0] events;
	logic [31:0] pend_r;

	// Tracks the pads on every clock; holds last value if the clock stops
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_smp_r <= RST_ZERO;
		end else begin
			pin_smp_r <= pad_in_i & IMPL_MASK;
		end
	end

	pic_line_filter u_filter (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_i),
		.raw_i     (pin_smp_r),
		.filt_en_i (gf_r),
		.slow_en_i (db_r),
		.div_i     (db_div_r),
		.level_o   (level)
	);

	pic_event_detect u_events (
		.sys_clk_i    (sys_clk_i),
		.rst_n_i      (rst_n_i),
		.level_i      (level),
		.extra_mode_i (aim_r),
		.level_mode_i (elvl_r),
		.high_rise_i  (pol_r),
		.event_o      (events)
	);

	// Read clears only the bits returned; new events win over the clear
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pend_r <= RST_ZERO;
		end else if (rd_acc && avs_address_i == OFS_IRQ_PEND) begin
			pend_r <= ((pend_r & ~readdata_r) | events) & IMPL_MASK;
		end else begin
			pend_r <= (pend_r | events) & IMPL_MASK;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(pend_r & imask_r);
		end
	end

	// ---------------------------------------------------------------
	// Write lock
	// ---------------------------------------------------------------
	logic [31:0] wl_mode_r;
	logic        wl_viol_r;
	logic [15:0] wl_src_r;
	logic        viol_now;

	assign lock_en  = wl_mode_r[WL_ENABLE_BIT];
	assign viol_now = wr_acc & lock_en & is_locked_ofs(avs_address_i);

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wl_mode_r <= RST_ZERO;
		end else if (wr_acc && avs_address_i == OFS_WL_MODE) begin
			wl_mode_r <= (wl_mode_r & ~be_mask) | wreg;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wl_viol_r <= 1'b0;
			wl_src_r  <= 16'h0000;
		end else if (viol_now) begin
			wl_viol_r <= 1'b1;
			wl_src_r  <= {7'h00, avs_address_i};
		end else if (rd_acc && avs_address_i == OFS_WL_ST
			&& readdata_r[WL_VIOL_BIT]) begin
			wl_viol_r <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Read mux
	// ---------------------------------------------------------------
	always_comb begin
		case (avs_address_i)
			OFS_OWN_ST:   rd_val = own_view & IMPL_MASK;
			OFS_OE_ST:    rd_val = oe_r & IMPL_MASK;
			OFS_GF_ST:    rd_val = gf_r & IMPL_MASK;
			OFS_OUT_VAL:  rd_val = out_r & IMPL_MASK;
			OFS_PIN_SMP:  rd_val = pin_smp_r & IMPL_MASK;
			OFS_IRQ_MASK: rd_val = imask_r & IMPL_MASK;
			OFS_IRQ_PEND: rd_val = pend_r & IMPL_MASK;
			OFS_OD_ST:    rd_val = od_r & IMPL_MASK;
			OFS_PU_ST:    rd_val = pu_r & IMPL_MASK;
			OFS_PSEL_LO:  rd_val = psel_lo_r & IMPL_MASK;
			OFS_PSEL_HI:  rd_val = psel_hi_r & IMPL_MASK;
			OFS_DB_ST:    rd_val = db_r & IMPL_MASK;
			OFS_DB_DIV:   rd_val = db_div_r;
			OFS_PD_ST:    rd_val = pd_r & IMPL_MASK;
			OFS_DW_ST:    rd_val = dw_r & IMPL_MASK;
			OFS_AIM_MASK: rd_val = aim_r & IMPL_MASK;
			OFS_EL_ST:    rd_val = elvl_r & IMPL_MASK;
			OFS_POL_ST:   rd_val = pol_r & IMPL_MASK;
			OFS_WL_MODE:  rd_val = wl_mode_r;
			OFS_WL_ST:    rd_val = {8'h00, wl_src_r, 7'h00, wl_viol_r};
			OFS_SCHMITT:  rd_val = schmitt_r & IMPL_MASK;
			OFS_DRIVE:    rd_val = drive_r & IMPL_MASK;
			default:      rd_val = RST_ZERO;
		endcase
	end

	// ---------------------------------------------------------------
	// Pin multiplexing and pad control
	// ---------------------------------------------------------------
	logic [31:0] mux_out;
	logic [31:0] mux_oe;
	logic [31:0] drv_out;
	logic [31:0] drv_oe;

	// Each line n picks peripheral {hi[n],lo[n]} from the four 32-bit slices
	always_comb begin
		mux_out = RST_ZERO;
		mux_oe  = RST_ZERO;
		for (int n = 0; n < NUM_LINES; n++) begin
			mux_out[n] = periph_out_i[{psel_hi_r[n], psel_lo_r[n], 5'(n)}];
			mux_oe[n]  = periph_oe_i[{psel_hi_r[n], psel_lo_r[n], 5'(n)}];
		end
	end

	// Open-drain lines only drive while low
	assign drv_out = (own_view & out_r) | (~own_view & mux_out);
	assign drv_oe  = ((own_view & oe_r) | (~own_view & mux_oe)) & ~(od_r & drv_out);

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pad_out_o <= RST_ZERO;
			pad_oe_o  <= RST_ZERO;
		end else begin
			pad_out_o <= drv_out & IMPL_MASK;
			pad_oe_o  <= drv_oe & IMPL_MASK;
		end
	end

	assign pad_pullup_o      = pu_r & IMPL_MASK;
	assign pad_pulldown_o    = pd_r & IMPL_MASK;
	assign pad_schmitt_off_o = schmitt_r & IMPL_MASK;
	assign pad_drive_o       = drive_r & IMPL_MASK;
	assign periph_in_o       = level;
endmodule

// ### bench/pic_parallel_io_checker.sv
// Checker for the parallel I/O controller, attached to its top module by bind.
// Assumes one clock domain and the bus timing of the controller's register port.
`timescale 1ns/1ps
module pic_parallel_io_checker
	import pic_pkg::*;
#(
	parameter logic [31:0] IMPL_MASK = 32'hFFFF_FFFF,
	parameter logic [31:0] MUX_MASK  = 32'hFFFF_FFFF
) (
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [8:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	input  wire logic [31:0] avs_readdata_o,
	input  wire logic        avs_waitrequest_o,
	input  wire logic [31:0] pad_oe_o,
	input  wire logic        irq_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	logic       rd_ok;
	logic       wr_ok;
	logic       prot;
	logic       lk_r;
	logic       vio_r;
	logic [8:0] src_r;
	assign rd_ok = avs_read_i && !avs_waitrequest_o;
	assign wr_ok = avs_write_i && !avs_waitrequest_o;
	assign prot = avs_address_i inside {OFS_OWN_EN, OFS_OWN_DIS, OFS_OE_EN, OFS_OE_DIS,
		OFS_GF_EN, OFS_GF_DIS, OFS_OD_EN, OFS_OD_DIS, OFS_PU_DIS, OFS_PU_EN, OFS_PSEL_LO,
		OFS_PSEL_HI, OFS_DW_EN, OFS_DW_DIS, OFS_PD_DIS, OFS_PD_EN};
	// Mirror of the lock bit
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			lk_r <= 1'b0;
		else if (wr_ok && avs_address_i == OFS_WL_MODE && avs_byteenable_i[0])
			lk_r <= avs_writedata_i[0];
	end
	// Expected violation flag and source
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			vio_r <= 1'b0;
			src_r <= 9'h000;
		end else if (wr_ok && lk_r && prot) begin
			vio_r <= 1'b1;
			src_r <= avs_address_i;
		end else if (rd_ok && avs_address_i == OFS_WL_ST)
			vio_r <= 1'b0;
	end
	chk_unimpl_zero: assert property (rd_ok |-> (avs_readdata_o & ~IMPL_MASK) == 32'h0)
		else $error("unimplemented line bit read nonzero");
	chk_reserved_zero: assert property (rd_ok && (avs_address_i == 9'h00C ||
		avs_address_i == 9'h0E0 || avs_address_i >= 9'h114) |-> avs_readdata_o == 32'h0)
		else $error("reserved offset read nonzero");
	chk_own_fixed: assert property (rd_ok && avs_address_i == OFS_OWN_ST
		|-> (avs_readdata_o | MUX_MASK | ~IMPL_MASK) == 32'hFFFF_FFFF)
		else $error("unmultiplexed line not owned");
	chk_mask_irq: assert property (rd_ok && avs_address_i == OFS_IRQ_MASK
		&& avs_readdata_o == 32'h0 |=> !irq_o)
		else $error("irq high with empty mask");
	chk_reset_irq: assert property ($rose(rst_n_i) |-> !irq_o)
		else $error("irq high after reset");
	chk_oe_off: assert property (wr_ok && !lk_r && avs_address_i == OFS_OE_DIS &&
		avs_byteenable_i == 4'hF |-> ##2
		(pad_oe_o & $past(avs_writedata_i, 2) & ~MUX_MASK & IMPL_MASK) == 32'h0)
		else $error("output drive not released");
	chk_lock_src: assert property (rd_ok && avs_address_i == OFS_WL_ST && vio_r
		|-> avs_readdata_o[0] && avs_readdata_o[23:8] == {7'h00, src_r})
		else $error("lock violation not reported");
	chk_lock_clear: assert property (rd_ok && avs_address_i == OFS_WL_ST && !vio_r
		|-> !avs_readdata_o[0])
		else $error("lock violation flag not cleared");
	cover property (rd_ok && avs_address_i == OFS_IRQ_PEND);
	cover property ($rose(irq_o));
	cover property (wr_ok && lk_r && prot);
endmodule

bind pic_parallel_io pic_parallel_io_checker #(.IMPL_MASK(IMPL_MASK), .MUX_MASK(MUX_MASK)) u_chk (
	.sys_clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
	.avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .pad_oe_o, .irq_o);

// ### bench/pic_pad_model.sv
// Pad model: a line is driven by the controller, by an outside source, or floats.
// Assumes one clock; a floating line without pull shows the inverse of its last level.
`timescale 1ns/1ps
module pic_pad_model (
	input  wire logic        clk_i,
	input  wire logic [31:0] out_i,
	input  wire logic [31:0] oe_i,
	input  wire logic [31:0] pu_i,
	input  wire logic [31:0] pd_i,
	input  wire logic [31:0] ext_i,
	input  wire logic [31:0] ext_en_i,
	output logic      [31:0] pad_o
);
	logic [31:0] last;
	always_ff @(posedge clk_i)
		last <= pad_o;
	assign pad_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_i)
		| (~oe_i & ~ext_en_i & (pu_i | (~pd_i & ~last)));
endmodule

// ### bench/testbench.sv
// Self-checking bench for the parallel I/O controller.
// Assumes the pad model closes the pin loop and a single 40 MHz clock.
`timescale 1ns/1ps
module testbench
	import pic_pkg::*;
;
	localparam logic [31:0] IMPL = 32'h7FFF_FFFF;
	localparam logic [31:0] MUX  = 32'hFFFF_FF00;
	logic        clk, rst_n, rd, wr, wt, irq;
	logic [8:0]  addr;
	logic [3:0]  be;
	logic [31:0] wd, rdat, pin, pout, poe, ppu, ppd, ext, exen, d;
	int          miscompares, tests_run;
	pic_parallel_io #(.IMPL_MASK(IMPL), .MUX_MASK(MUX)) uut (
		.sys_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(addr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wt), .pad_in_i(pin), .pad_out_o(pout),
		.pad_oe_o(poe), .pad_pullup_o(ppu), .pad_pulldown_o(ppd), .pad_schmitt_off_o(),
		.pad_drive_o(), .periph_out_i(128'h0), .periph_oe_i(128'h0), .periph_in_o(),
		.irq_o(irq));
	pic_pad_model pads (.clk_i(clk), .out_i(pout), .oe_i(poe), .pu_i(ppu), .pd_i(ppd),
		.ext_i(ext), .ext_en_i(exen), .pad_o(pin));
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			miscompares++;
		end
	endtask
	task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] v);
		int n;
		n = 0;
		@(posedge clk);
		rd <= !w;
		wr <= w;
		addr <= a;
		wd <= v;
		do begin
			@(posedge clk);
			n++;
		end while (wt !== 1'b0 && n < 50);
		if (wt !== 1'b0) begin
			$display("BAD t=%0t bus stuck at %h got=%h exp=%h", $time, a, wt, 1'b0);
			miscompares++;
			give_verdict();
		end
		d = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic w32(input logic [8:0] a, input logic [31:0] v);
		bus(1'b1, a, v);
	endtask
	task automatic r32(input logic [8:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(d, e);
	endtask
	task automatic wait_irq(input logic v);
		int n;
		n = 0;
		while (irq !== v && n < 40) begin
			@(negedge clk);
			n++;
		end
		chk({31'h0, irq}, {31'h0, v});
		if (irq !== v)
			give_verdict();
	endtask
	task automatic t_reset();
		logic [8:0] z [17] = '{OFS_OE_ST, OFS_GF_ST, OFS_IRQ_MASK, OFS_OD_ST, OFS_PSEL_LO,
			OFS_PSEL_HI, OFS_DB_ST, OFS_DB_DIV, OFS_DW_ST, OFS_AIM_MASK, OFS_EL_ST,
			OFS_POL_ST, OFS_WL_MODE, OFS_WL_ST, OFS_SCHMITT, OFS_DRIVE, OFS_PU_ST};
		logic [8:0] rz [3] = '{9'h00C, 9'h0E0, 9'h114};
		foreach (z[i]) r32(z[i], 32'h0);
		r32(OFS_OWN_ST, IMPL);
		foreach (rz[i]) w32(rz[i], 32'hFFFF_FFFF);
		foreach (rz[i]) r32(rz[i], 32'h0);
		$display("reset test done");
	endtask
	task automatic t_setclr();
		w32(OFS_OE_EN, 32'hFFFF_FFFF);
		r32(OFS_OE_ST, IMPL);
		w32(OFS_OE_DIS, 32'h0000_00F0);
		r32(OFS_OE_ST, IMPL & 32'hFFFF_FF0F);
		w32(OFS_SCHMITT, 32'hFFFF_FFFF);
		r32(OFS_SCHMITT, IMPL);
		w32(OFS_SCHMITT, 32'h0);
		w32(OFS_PU_EN, 32'h0000_0003);
		r32(OFS_PU_ST, 32'h0000_0003);
		chk(ppu, 32'h0000_0003);
		w32(OFS_GF_EN, 32'h0000_0020);
		r32(OFS_GF_ST, 32'h0000_0020);
		$display("set clear test done");
	endtask
	task automatic t_direct();
		w32(OFS_OUT_CLR, 32'hFFFF_FFFF);
		w32(OFS_DW_EN, 32'h0000_000F);
		w32(OFS_OUT_VAL, 32'hFFFF_FFFF);
		r32(OFS_OUT_VAL, 32'h0000_000F);
		bus(1'b0, OFS_PIN_SMP, 32'h0);
		chk(d & 32'hFF, 32'h0000_00AF);
		chk(pout & 32'hFF, 32'h0000_000F);
		$display("direct write test done");
	endtask
	task automatic t_irq();
		w32(OFS_IRQ_EN, 32'h0000_0020);
		bus(1'b0, OFS_IRQ_PEND, 32'h0);
		wait_irq(1'b0);
		@(posedge clk);
		ext <= 32'h0000_0080;
		wait_irq(1'b1);
		bus(1'b0, OFS_IRQ_PEND, 32'h0);
		chk(d & 32'h20, 32'h20);
		wait_irq(1'b0);
		w32(OFS_AIM_EN, 32'h0000_0020);
		w32(OFS_LVL_SEL, 32'h0000_0020);
		w32(OFS_FALL_SEL, 32'h0000_0020);
		bus(1'b0, OFS_IRQ_PEND, 32'h0);
		bus(1'b0, OFS_IRQ_PEND, 32'h0);
		chk(d & 32'h20, 32'h20);
		w32(OFS_IRQ_DIS, 32'h0000_0020);
		r32(OFS_IRQ_MASK, 32'h0);
		wait_irq(1'b0);
		$display("interrupt test done");
	endtask
	task automatic t_lock();
		w32(OFS_WL_MODE, 32'h0000_0001);
		w32(OFS_OE_EN, 32'h0000_00F0);
		r32(OFS_OE_ST, IMPL & 32'hFFFF_FF0F);
		r32(OFS_WL_ST, 32'h0000_1001);
		r32(OFS_WL_ST, 32'h0000_1000);
		w32(OFS_WL_MODE, 32'h0);
		w32(OFS_OE_EN, 32'h0000_00F0);
		r32(OFS_OE_ST, IMPL);
		$display("lock test done");
	endtask
	task automatic t_own();
		w32(OFS_OWN_DIS, 32'hFFFF_FFFF);
		r32(OFS_OWN_ST, IMPL & ~MUX);
		w32(OFS_OWN_EN, 32'h0000_0100);
		r32(OFS_OWN_ST, 32'h0000_01FF);
		$display("ownership test done");
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		rst_n = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		addr = 9'h000;
		wd = 32'h0;
		be = 4'hF;
		ext = 32'h0000_00A0;
		exen = 32'hFFFF_FFFF;
		miscompares = 0;
		tests_run = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_setclr();
		t_direct();
		t_irq();
		t_lock();
		t_own();
		give_verdict();
	end
endmodule
